// >>> inc/dmr_pkg.sv
package dmr_pkg;
  // command encodings on {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_NOP = 3'h7;
  // bank select values
  localparam logic [2:0] BANK_MODE = 3'h0;
  localparam logic [2:0] BANK_EXT = 3'h1;
  localparam int ADDR_W = 14;
  localparam int REG_W = 17;
  // mode register fields
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int MR_TM_BIT = 7;
  localparam int MR_DLLRST_BIT = 8;
  localparam int MR_WR_LSB = 9;
  localparam int MR_PD_BIT = 12;
  // extended mode register fields
  localparam int EMR_DLLDIS_BIT = 0;
  localparam int EMR_DRV_BIT = 1;
  localparam int EMR_AL_LSB = 3;
  localparam int EMR_CAL_LSB = 7;
  localparam int EMR_NSTB_DIS_BIT = 10;
  localparam int EMR_XSTB_EN_BIT = 11;
  localparam int EMR_QOFF_BIT = 12;
  localparam logic [2:0] BL4_CODE = 3'h2;
  localparam logic [2:0] BL8_CODE = 3'h3;
  localparam logic [3:0] CL_MIN = 4'h3;
  localparam logic [3:0] CL_MAX = 4'h7;
  localparam logic [3:0] WR_MIN = 4'h2;
  localparam logic [3:0] WR_MAX = 4'h8;
  localparam logic [3:0] AL_MAX = 4'h6;
  localparam logic [REG_W-1:0] MR_RESET = 17'h0_0032;
  localparam logic [REG_W-1:0] EMR_RESET = 17'h0_0000;
  localparam int PIPE_D = 16;
  localparam int SR_W = 3;
  localparam logic [4:0] WR_CNT_ZERO = 5'h00;
  localparam logic [4:0] ONE5 = 5'h01;
  localparam logic [3:0] ONE4 = 4'h1;

  typedef struct packed {
    logic [2:0] cmd;
    logic [2:0] bank;
    logic [ADDR_W-1:0] addr;
    logic cke;
  } dmr_cmd_t;

  typedef struct packed {
    logic [3:0] cas_lat;
    logic [3:0] add_lat;
    logic [3:0] wr_rec;
    logic burst8;
    logic interleave;
    logic slow_exit;
    logic drive_reduced;
    logic dll_on;
    logic test_mode;
  } dmr_cfg_t;

  typedef enum logic [1:0] {
    PD_NONE = 2'b00,
    PD_FAST = 2'b01,
    PD_SLOW = 2'b10,
    PD_PRE = 2'b11
  } dmr_pd_t;
endpackage

// >>> verilog/dmr_mode_decode.sv
`timescale 1ns/1ps
// Behaviour
// RULE1: mode load with test bit 0 stores fields; with 1 only enters test mode
// RULE2: dll reset bit starts a loop reset and clears itself next cycle
// RULE3: controller waits 200 clocks after loop reset before read
// RULE4: auto precharge after write waits write recovery clocks after last data
// RULE5: controller programs write recovery 2..8, no reserved codes
// RULE6: power-down select 0 gives fast exit, loop running
// RULE7: power-down select 1 gives slow exit, loop frozen
// RULE8: cas latency field selects whole clocks 3 to 7
// RULE9: read data starts cas latency clocks after the read edge
// RULE10: with additive latency, reads are held that many clocks first
// RULE11: controller loads extended register only idle, then waits set delay
// RULE12: extended register holds until rewritten; array untouched
// RULE13: controller follows loop enable with reset and 200 clock wait
// RULE14: self refresh turns loop off; exit re-enables and resets it
// RULE15: controller adds precharge-all after refresh when slow and loop off
// RULE16: drive bit 0 full drive, 1 reduced drive
// RULE17: complement disable 0 gives inverse strobe pin, 1 single-ended
// RULE18: complementary read strobe only with read strobe on, complement on
// RULE19: extra read strobe follows data strobe on reads, ignored on writes; code follows strobe whenever enabled, writes too
// RULE20: output disable turns off all data and strobe outputs
// RULE21: controller writes zero above the output-disable bit
// RULE22: controller sets calibration bits to ones then zeros during init
// RULE23: burst length field picks four or eight, reads and writes alike
// RULE24: additive latency 0..6; read latency al+cl, write one less
// RULE25: controller loads mode register only idle, then waits set delay
// RULE26: bank lines pick register, address lines carry bits, taken on edge
module dmr_mode_decode
  import dmr_pkg::*;
(
  input wire logic clk_i, // device clock
  input wire logic rst_i, // sync reset, high
  input wire dmr_cmd_t cmd_i, // registered command bus
  input wire logic autopre_i, // a10 of write: auto precharge
  input wire logic last_wdata_i, // last data beat of a write burst
  input wire logic pd_entry_i, // active power-down entry
  input wire logic strobe_i, // internal data strobe
  output dmr_cfg_t cfg_o, // decoded config
  output logic dll_reset_o, // loop reset pulse
  output logic dll_run_o, // loop running
  output logic dll_frozen_o, // loop frozen in slow exit
  output dmr_pd_t pd_mode_o, // power-down mode
  output logic int_read_o, // read issued internally
  output logic rdata_start_o, // first read data slot
  output logic precharge_o, // internal auto precharge
  output logic dq_oe_n_o, // data out enable, low drives
  output logic strobe_oe_n_o, // strobe out enable
  output logic nstrobe_oe_n_o, // complement strobe enable
  output logic xstrobe_oe_n_o, // extra read strobe enable
  output logic nxstrobe_oe_n_o, // complementary read strobe enable
  output logic xstrobe_o, // extra read strobe level
  output logic [3:0] wlat_o // write latency
);

  ////////////////////////////////////////////////////////////////////////
  logic [REG_W-1:0] mr_q, mr_d, emr_q, emr_d;
  logic test_q, test_d;
  logic in_sr_q;
  wire [REG_W-1:0] cap_word = {cmd_i.bank, cmd_i.addr};
  wire is_load = cmd_i.cmd == CMD_LOAD_MODE && cmd_i.cke;
  wire ld_mr = is_load && cmd_i.bank == BANK_MODE; // RULE26
  wire ld_emr = is_load && cmd_i.bank == BANK_EXT; // RULE26
  wire ld_test = ld_mr && cmd_i.addr[MR_TM_BIT];
  wire sr_entry = cmd_i.cmd == CMD_REFRESH && !cmd_i.cke && !in_sr_q;
  wire sr_exit = in_sr_q && cmd_i.cke;

  always_comb begin
    mr_d = mr_q;
    test_d = test_q;
    if (ld_mr) begin
      test_d = cmd_i.addr[MR_TM_BIT]; // RULE1
      // test load touches no other field
      if (!ld_test) begin
        mr_d = cap_word; // RULE1
      end
    end
    if (!ld_mr || ld_test) begin
      mr_d[MR_DLLRST_BIT] = 1'b0; // RULE2
    end
  end

  // only rewritten on its own load; nothing else disturbs it
  assign emr_d = ld_emr ? cap_word : emr_q; // RULE12

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mr_q <= MR_RESET;
      emr_q <= EMR_RESET;
      test_q <= 1'b0;
      in_sr_q <= 1'b0;
    end else begin
      mr_q <= mr_d;
      emr_q <= emr_d;
      test_q <= test_d;
      in_sr_q <= sr_entry ? 1'b1 : (sr_exit ? 1'b0 : in_sr_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  wire [3:0] cl_w = {1'b0, mr_q[MR_CL_LSB +: 3]}; // RULE8
  wire [3:0] wr_w = {1'b0, mr_q[MR_WR_LSB +: 3]} + ONE4; // RULE4
  wire [3:0] al_w = {1'b0, emr_q[EMR_AL_LSB +: 3]}; // RULE24
  wire [3:0] rl_w = al_w + cl_w; // RULE24
  wire dll_en = !emr_q[EMR_DLLDIS_BIT];
  wire qoff = emr_q[EMR_QOFF_BIT];
  wire nstb_on = !emr_q[EMR_NSTB_DIS_BIT]; // RULE17
  wire xstb_on = emr_q[EMR_XSTB_EN_BIT];
  wire nxstb_on = xstb_on && nstb_on; // RULE18
  dmr_cfg_t cfg_w;
  assign cfg_w.cas_lat = cl_w;
  assign cfg_w.add_lat = al_w;
  assign cfg_w.wr_rec = wr_w;
  assign cfg_w.burst8 = mr_q[MR_BL_LSB +: 3] == BL8_CODE; // RULE23
  assign cfg_w.interleave = mr_q[MR_BT_BIT];
  assign cfg_w.slow_exit = mr_q[MR_PD_BIT];
  assign cfg_w.drive_reduced = emr_q[EMR_DRV_BIT]; // RULE16
  assign cfg_w.dll_on = dll_en;
  assign cfg_w.test_mode = test_q;

  ////////////////////////////////////////////////////////////////////////
  // read pipeline: al stage then cl stage, shift by one per clock
  wire is_read = cmd_i.cmd == CMD_READ && cmd_i.cke;
  logic [PIPE_D-1:0] rd_pipe_q;
  logic [PIPE_D-1:0] rd_pipe_d;
  assign rd_pipe_d = {rd_pipe_q[PIPE_D-2:0], is_read};
  // tap k of pipe = read seen k+1 edges ago
  wire int_rd_w = (al_w == 4'h0) ? is_read : rd_pipe_q[al_w - ONE4]; // RULE10
  wire rstart_w = rd_pipe_q[rl_w - ONE4 - ONE4]; // RULE9

  // write recovery countdown to internal precharge
  logic [4:0] wr_cnt_q;
  logic ap_pend_q;
  wire wr_arm = ap_pend_q && last_wdata_i;
  wire wr_fire = wr_cnt_q == ONE5;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_pipe_q <= '0;
      wr_cnt_q <= WR_CNT_ZERO;
      ap_pend_q <= 1'b0;
    end else begin
      rd_pipe_q <= rd_pipe_d;
      if (cmd_i.cmd == CMD_WRITE && cmd_i.cke) begin
        ap_pend_q <= autopre_i;
      end else if (wr_arm) begin
        ap_pend_q <= 1'b0;
      end
      if (wr_arm) begin
        // one short: the registered output spends the last clock
        wr_cnt_q <= {1'b0, wr_w - ONE4}; // RULE4
      end else if (wr_cnt_q != WR_CNT_ZERO) begin
        wr_cnt_q <= wr_cnt_q - ONE5;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power-down and loop state
  wire [1:0] pd_w = !pd_entry_i ? PD_NONE :
                    (!mr_q[MR_PD_BIT] ? PD_FAST : PD_SLOW); // RULE6 RULE7
  wire dll_rst_w = (ld_mr && !ld_test && cmd_i.addr[MR_DLLRST_BIT]) || sr_exit; // RULE2 RULE14
  wire dll_run_w = dll_en && !in_sr_q && !(pd_entry_i && mr_q[MR_PD_BIT]); // RULE14 RULE6
  wire dll_frz_w = dll_en && pd_entry_i && mr_q[MR_PD_BIT]; // RULE7

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_o <= '0;
      dll_reset_o <= 1'b0;
      dll_run_o <= 1'b0;
      dll_frozen_o <= 1'b0;
      pd_mode_o <= PD_NONE;
      int_read_o <= 1'b0;
      rdata_start_o <= 1'b0;
      precharge_o <= 1'b0;
      dq_oe_n_o <= 1'b1;
      strobe_oe_n_o <= 1'b1;
      nstrobe_oe_n_o <= 1'b1;
      xstrobe_oe_n_o <= 1'b1;
      nxstrobe_oe_n_o <= 1'b1;
      xstrobe_o <= 1'b0;
      wlat_o <= 4'h0;
    end else begin
      cfg_o <= cfg_w;
      dll_reset_o <= dll_rst_w;
      dll_run_o <= dll_run_w;
      dll_frozen_o <= dll_frz_w;
      pd_mode_o <= dmr_pd_t'(pd_w);
      int_read_o <= int_rd_w;
      rdata_start_o <= rstart_w;
      precharge_o <= wr_fire; // RULE4
      dq_oe_n_o <= qoff; // RULE20
      strobe_oe_n_o <= qoff; // RULE20
      nstrobe_oe_n_o <= qoff || !nstb_on; // RULE17 RULE20
      xstrobe_oe_n_o <= qoff || !xstb_on; // RULE19 RULE20
      nxstrobe_oe_n_o <= qoff || !nxstb_on; // RULE18 RULE20
      xstrobe_o <= xstb_on && strobe_i; // RULE19
      wlat_o <= rl_w - ONE4; // RULE24
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  test_guard_a: assert property (ld_test |=> mr_q[MR_CL_LSB +: 3] == $past(mr_q[MR_CL_LSB +: 3]))
    else $error("test load changed a mode field"); // RULE1
  mode_store_a: assert property (ld_mr && !ld_test |=> mr_q[MR_WR_LSB +: 3] == $past(cmd_i.addr[MR_WR_LSB +: 3]))
    else $error("mode field not stored"); // RULE1
  dll_selfclr_a: assert property (##1 !mr_q[MR_DLLRST_BIT] || $past(ld_mr))
    else $error("dll reset bit stuck"); // RULE2
  dll_pulse_a: assert property (dll_rst_w |=> dll_reset_o ##1 (!dll_reset_o || $past(dll_rst_w)))
    else $error("dll reset pulse wrong"); // RULE2
  ext_hold_a: assert property (!ld_emr |=> $stable(emr_q))
    else $error("extended register changed without load"); // RULE12
  rd_lat_a: assert property (is_read && al_w == 4'h0 && cl_w == CL_MIN && $stable(mr_q) [*1]
    |-> ##3 rdata_start_o)
    else $error("read data late or early"); // RULE9
  al_hold_a: assert property (is_read && al_w == 4'h2 |-> ##3 int_read_o)
    else $error("additive latency hold wrong"); // RULE10
  qoff_a: assert property (qoff |=> dq_oe_n_o && strobe_oe_n_o && xstrobe_oe_n_o && nxstrobe_oe_n_o)
    else $error("outputs not disabled"); // RULE20
  nx_strobe_a: assert property (!nxstrobe_oe_n_o |-> $past(xstb_on && nstb_on))
    else $error("complementary read strobe wrong"); // RULE18
  sr_dll_a: assert property (in_sr_q |=> !dll_run_o)
    else $error("loop running in self refresh"); // RULE14
  wr_pre_a: assert property (wr_arm && wr_w == WR_MIN |-> ##2 precharge_o)
    else $error("precharge timing wrong"); // RULE4
  pd_sel_a: assert property (pd_entry_i && mr_q[MR_PD_BIT] |=> pd_mode_o == PD_SLOW && !dll_run_o)
    else $error("slow exit mode wrong"); // RULE7


  ////////////////////////////////////////////////////////////////////////
  // decoded fields reach the outputs one clock after the registers
  test_set_a: assert property (ld_test |=> test_q) // RULE1
    else $error("test mode not entered");
  test_clr_a: assert property (ld_mr && !ld_test |=> !test_q) // RULE1
    else $error("test mode not left");
  emr_load_a: assert property (ld_emr |=> emr_q == $past(cap_word)) // RULE26
    else $error("extended register not stored");
  bank_other_a: assert property (is_load && cmd_i.bank != BANK_MODE && cmd_i.bank != BANK_EXT
    |=> $stable(mr_q[MR_CL_LSB +: 3]) && $stable(emr_q)) // RULE26
    else $error("unused bank changed a register");
  burst_out_a: assert property (1'b1 |=> cfg_o.burst8 == ($past(mr_q[MR_BL_LSB +: 3]) == BL8_CODE)) // RULE23
    else $error("burst length decode wrong");
  wlat_out_a: assert property (1'b1 |=> wlat_o == $past(rl_w) - ONE4) // RULE24
    else $error("write latency wrong");
  drive_out_a: assert property (1'b1 |=> cfg_o.drive_reduced == $past(emr_q[EMR_DRV_BIT])) // RULE16
    else $error("drive strength decode wrong");

  ////////////////////////////////////////////////////////////////////////
  // power-down and loop
  pd_fast_a: assert property (pd_entry_i && !mr_q[MR_PD_BIT] |=> pd_mode_o == PD_FAST) // RULE6
    else $error("fast exit mode wrong");
  pd_none_a: assert property (!pd_entry_i |=> pd_mode_o == PD_NONE) // RULE6
    else $error("power-down shown while active");
  fast_run_a: assert property (pd_entry_i && !mr_q[MR_PD_BIT] && dll_en && !in_sr_q |=> dll_run_o) // RULE6
    else $error("loop stopped in fast exit");
  frz_excl_a: assert property (dll_frozen_o |-> !dll_run_o) // RULE7
    else $error("loop frozen and running");
  sr_reset_a: assert property (sr_exit |=> dll_reset_o) // RULE14
    else $error("no loop reset on self refresh exit");

  ////////////////////////////////////////////////////////////////////////
  // strobe and output enables
  nstb_on_a: assert property (!qoff && nstb_on |=> !nstrobe_oe_n_o) // RULE17
    else $error("complement strobe not enabled");
  nstb_off_a: assert property (!nstb_on |=> nstrobe_oe_n_o) // RULE17
    else $error("complement strobe not disabled");
  nx_on_a: assert property (!qoff && xstb_on && nstb_on |=> !nxstrobe_oe_n_o) // RULE18
    else $error("complementary read strobe not enabled");
  x_idle_a: assert property (!xstb_on |=> !xstrobe_o) // RULE19
    else $error("extra strobe moves while off");
  x_follow_a: assert property (xstb_on |=> xstrobe_o == $past(strobe_i)) // RULE19
    else $error("extra strobe does not follow strobe");
  dq_on_a: assert property (!qoff |=> !dq_oe_n_o && !strobe_oe_n_o) // RULE20
    else $error("outputs off while enabled");

  ////////////////////////////////////////////////////////////////////////
  // read and precharge timing
  al_zero_a: assert property (is_read && al_w == 4'h0 |=> int_read_o) // RULE10
    else $error("read held without additive latency");
  rd_cl4_a: assert property (is_read && al_w == 4'h0 && cl_w == 4'h4 |-> ##4 rdata_start_o) // RULE9
    else $error("read data late for latency four");
  pre_quiet_a: assert property (!wr_fire |=> !precharge_o) // RULE4
    else $error("precharge without countdown");

  read_c: cover property (is_read ##[1:20] rdata_start_o);
  testmode_c: cover property (ld_test);
  autopre_c: cover property (wr_arm ##[1:10] precharge_o);
  srexit_c: cover property (sr_exit);
endmodule

// >>> bench/dmr_ctrl_model.sv
`timescale 1ns/1ps
module dmr_ctrl_model
  import dmr_pkg::*;
#(
  parameter int MRD = 2,
  parameter int LOCK = 200
)
(
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire dmr_cmd_t req_i, // wanted command
  input wire logic req_v_i, // request pending
  output logic sent_o, // request leaves at next edge
  output dmr_cmd_t cmd_o // command bus to the device
);
  int gap_q;
  int lock_q;
  logic is_load;
  logic is_read;
  assign is_load = req_i.cmd == CMD_LOAD_MODE;
  assign is_read = req_i.cmd == CMD_READ;
  // clock stays above 25 MHz, so no precharge-all after refresh is owed
  // holding back is safer than trusting the bench to pace itself
  assign sent_o = req_v_i && gap_q == 0 && !(is_read && lock_q < LOCK);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_o <= '{cmd: CMD_NOP, bank: 3'h0, addr: 14'h0000, cke: 1'b1};
      gap_q <= 0;
      lock_q <= LOCK;
    end else begin
      cmd_o <= '{cmd: CMD_NOP, bank: 3'h0, addr: 14'h0000, cke: cmd_o.cke};
      gap_q <= (gap_q > 0) ? gap_q - 1 : 0;
      if (lock_q < LOCK) lock_q <= lock_q + 1;
      if (sent_o) begin
        cmd_o <= req_i;
        if (is_load) cmd_o.addr[13] <= 1'b0;
        if (is_load) gap_q <= MRD;
        if ((is_load && req_i.bank == BANK_MODE && req_i.addr[MR_DLLRST_BIT]) || (req_i.cke && !cmd_o.cke))
          lock_q <= 0;
      end
    end
  end
endmodule

// >>> bench/test_dmr_mode_decode.sv
`timescale 1ns/1ps
module test_dmr_mode_decode;
  import dmr_pkg::*;
  `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
  typedef struct packed {logic [2:0] b; logic [13:0] a; logic [3:0] cl; logic [3:0] wr; logic [3:0] al;} dmr_row_t;
  dmr_row_t rows [8] = '{'{BANK_MODE, 14'h0232, 4'h3, 4'h2, 4'h0}, '{BANK_MODE, 14'h0442, 4'h4, 4'h3, 4'h0},
    '{BANK_MODE, 14'h0652, 4'h5, 4'h4, 4'h0}, '{BANK_MODE, 14'h0862, 4'h6, 4'h5, 4'h0},
    '{BANK_MODE, 14'h1e72, 4'h7, 4'h8, 4'h0}, '{BANK_MODE, 14'h0c72, 4'h7, 4'h7, 4'h0},
    '{BANK_EXT, 14'h0032, 4'h7, 4'h7, 4'h6}, '{BANK_EXT, 14'h0000, 4'h7, 4'h7, 4'h0}};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  dmr_cmd_t req = '{cmd: CMD_NOP, bank: 3'h0, addr: 14'h0000, cke: 1'b1};
  logic req_v = 1'b0, autopre = 1'b0, last_w = 1'b0, pd_entry = 1'b0, strobe = 1'b0, sent;
  dmr_cmd_t cmd;
  dmr_cfg_t cfg;
  dmr_pd_t pd_mode;
  logic dll_reset, dll_run, dll_frozen, int_read, rdata_start, precharge, dq_oe_n, xstrobe;
  logic strobe_oe_n, nstrobe_oe_n, xstrobe_oe_n, nxstrobe_oe_n;
  logic [3:0] wlat;
  int miscompares = 0, n_checks = 0, cyc = 0, t_rd, t_rs, t_lw, t_pc, t_ir, n_rst = 0, n_drv = 0, n0, d;
  initial forever #10 clk_i = ~clk_i;
  dmr_ctrl_model ctrl (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .req_v_i(req_v), .sent_o(sent), .cmd_o(cmd));
  dmr_mode_decode dut (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .autopre_i(autopre), .last_wdata_i(last_w),
    .pd_entry_i(pd_entry), .strobe_i(strobe), .cfg_o(cfg), .dll_reset_o(dll_reset), .dll_run_o(dll_run),
    .dll_frozen_o(dll_frozen), .pd_mode_o(pd_mode), .int_read_o(int_read), .rdata_start_o(rdata_start),
    .precharge_o(precharge), .dq_oe_n_o(dq_oe_n), .strobe_oe_n_o(strobe_oe_n), .nstrobe_oe_n_o(nstrobe_oe_n),
    .xstrobe_oe_n_o(xstrobe_oe_n), .nxstrobe_oe_n_o(nxstrobe_oe_n), .xstrobe_o(xstrobe), .wlat_o(wlat));
  ////////////////////////////////////////////////////////////////////////////
  // edge stamps, so latencies are measured rather than assumed
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    strobe <= ~strobe;
    if (cmd.cmd == CMD_READ && cmd.cke) t_rd <= cyc;
    if (rdata_start) t_rs <= cyc;
    if (int_read) t_ir <= cyc;
    if (last_w) t_lw <= cyc;
    if (precharge) t_pc <= cyc;
    if (dll_reset) n_rst <= n_rst + 1;
    if (!dq_oe_n) n_drv <= n_drv + 1;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic issue(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a, input logic k);
    int i;
    @(posedge clk_i);
    req <= '{cmd: c, bank: b, addr: a, cke: k};
    req_v <= 1'b1;
    for (i = 0; i < 400 && !sent; i++) @(negedge clk_i);
    if (!sent) begin miscompares++; final_report(); end
    @(posedge clk_i);
    req_v <= 1'b0;
  endtask
  task automatic do_read(input int rl, input int al, output int drv);
    int i, d0;
    d0 = n_drv;
    issue(CMD_READ, 3'h0, 14'h0000, 1'b1);
    for (i = 0; i < 20 && rdata_start !== 1'b1; i++) @(negedge clk_i);
    if (rdata_start !== 1'b1) begin miscompares++; final_report(); end
    repeat (6) @(negedge clk_i);
    `CHK(t_rs - t_rd, rl)
    `CHK(t_ir - t_rd, al + 1)
    drv = n_drv - d0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK({dq_oe_n, strobe_oe_n, nstrobe_oe_n, xstrobe_oe_n, nxstrobe_oe_n}, 5'h1f)
    @(negedge clk_i);
    `CHK(cfg.cas_lat, CL_MIN)
    `CHK(dq_oe_n, 1'b0)
    issue(CMD_LOAD_MODE, BANK_EXT, 14'h0380, 1'b1);
    issue(CMD_LOAD_MODE, BANK_EXT, 14'h0000, 1'b1);
    foreach (rows[r]) begin
      issue(CMD_LOAD_MODE, rows[r].b, rows[r].a, 1'b1);
      repeat (3) @(negedge clk_i);
      `CHK(cfg.cas_lat, rows[r].cl)
      `CHK(cfg.wr_rec, rows[r].wr)
      `CHK(cfg.add_lat, rows[r].al)
      `CHK(wlat, rows[r].cl + rows[r].al - 4'h1)
      if (rows[r].b == BANK_EXT) `CHK(cfg.drive_reduced, rows[r].a[EMR_DRV_BIT])
    end
    n0 = n_rst;
    issue(CMD_LOAD_MODE, BANK_MODE, 14'h0332, 1'b1);
    repeat (6) @(negedge clk_i);
    `CHK(n_rst - n0, 1)
    do_read(3, 0, d);
    `CHK(d > 0, 1'b1)
    // outputs off together with al 2: latency must still hold
    issue(CMD_LOAD_MODE, BANK_EXT, 14'h1010, 1'b1);
    repeat (3) @(negedge clk_i);
    do_read(5, 2, d);
    `CHK(d, 0)
    issue(CMD_LOAD_MODE, BANK_EXT, 14'h0800, 1'b1);
    repeat (3) @(negedge clk_i);
    `CHK({xstrobe_oe_n, nxstrobe_oe_n, nstrobe_oe_n}, 3'h0)
    `CHK(xstrobe, ~strobe)
    issue(CMD_LOAD_MODE, BANK_EXT, 14'h0c00, 1'b1);
    repeat (3) @(negedge clk_i);
    `CHK({xstrobe_oe_n, nxstrobe_oe_n, nstrobe_oe_n}, 3'h3)
    issue(CMD_LOAD_MODE, BANK_EXT, 14'h0000, 1'b1);
    @(posedge clk_i);
    autopre <= 1'b1;
    issue(CMD_WRITE, 3'h0, 14'h0400, 1'b1);
    repeat (3) @(posedge clk_i);
    last_w <= 1'b1;
    @(posedge clk_i);
    last_w <= 1'b0;
    autopre <= 1'b0;
    repeat (12) @(negedge clk_i);
    `CHK(t_pc - t_lw, 2)
    issue(CMD_LOAD_MODE, BANK_MODE, 14'h1232, 1'b1);
    @(posedge clk_i);
    pd_entry <= 1'b1;
    repeat (4) @(negedge clk_i);
    `CHK(pd_mode, PD_SLOW)
    `CHK(dll_frozen, 1'b1)
    @(posedge clk_i);
    pd_entry <= 1'b0;
    issue(CMD_LOAD_MODE, BANK_MODE, 14'h0232, 1'b1);
    @(posedge clk_i);
    pd_entry <= 1'b1;
    repeat (4) @(negedge clk_i);
    `CHK(pd_mode, PD_FAST)
    `CHK(dll_run, 1'b1)
    @(posedge clk_i);
    pd_entry <= 1'b0;
    issue(CMD_REFRESH, 3'h0, 14'h0000, 1'b0);
    repeat (4) @(negedge clk_i);
    `CHK(dll_run, 1'b0)
    n0 = n_rst;
    issue(CMD_NOP, 3'h0, 14'h0000, 1'b1);
    repeat (6) @(negedge clk_i);
    `CHK(n_rst - n0, 1)
    `CHK(dll_run, 1'b1)
    issue(CMD_LOAD_MODE, BANK_MODE, 14'h00d2, 1'b1);
    repeat (3) @(negedge clk_i);
    `CHK(cfg.test_mode, 1'b1)
    `CHK(cfg.cas_lat, 4'h3)
    final_report();
  end
endmodule
